//--- logic/cbiu_bus_unit.sv
// byte wide multiplexed bus interface unit with prefetch queue
`timescale 1ns/1ns
`include "cbiu_regs.svh"
// Overview of operation
// - address latch strobe pulses in T1
// - upper address held on dedicated lines
// - io_not_mem valid from T1 to T4
// - read floats bus at T2, strobe T2
// - minimum mode drives transceiver direction and enable
// - write data on bus T2 through T4
// - write strobe T2 through T3 and waits
// - acknowledge like read, address not driven
// - two acknowledges, type byte times four
// - maximum mode codes cycle type on status
// - word transfers as two byte cycles
// - four byte queue, fetch when space
// - word access costs four extra clocks
// - minimum mode lowest status bit on pin
// - io_not_mem high for io, low memory
// - halt delays latch strobe one clock
// - no high byte enable, one lane
// - strap selects direct strobes or coded status
module cbiu_bus_unit
  import cbiu_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic mode_strap_i,
  input wire logic ready_i,
  input wire logic [7:0] muxed_addr_data_low_i,
  output logic [7:0] muxed_addr_data_low_o,
  output logic muxed_addr_data_low_oe_o,
  output logic [7:0] upper_address_lines_o,
  output logic io_not_mem_o,
  output logic read_strobe_n_o,
  output logic write_strobe_n_o,
  output logic irq_ack_strobe_n_o,
  output logic addr_latch_strobe_o,
  output logic xcvr_direction_o,
  output logic xcvr_enable_n_o,
  output logic cycle_status_2_o,
  output logic cycle_status_1_o,
  output logic cycle_status_0_o,
  output logic min_mode_status_bit_o,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire cbiu_kind_e req_kind_i,
  input wire logic req_word_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [15:0] req_wdata_i,
  output logic rsp_valid_o,
  output logic [15:0] rsp_data_o,
  output logic [9:0] vector_ptr_o,
  input wire logic wake_i,
  input wire logic fetch_load_i,
  input wire logic [15:0] fetch_addr_i,
  output logic q_valid_o,
  output cbiu_byte_t q_data_o,
  input wire logic q_pop_i
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // status code of a cycle kind
  function automatic logic [2:0] cbiu_code(input cbiu_kind_e k);
    unique case (k)
      K_IRQ_ACK: cbiu_code = `CBIU_ST_IRQ_ACK;
      K_IO_RD: cbiu_code = `CBIU_ST_IO_RD;
      K_IO_WR: cbiu_code = `CBIU_ST_IO_WR;
      K_HALT: cbiu_code = `CBIU_ST_HALT;
      K_CODE: cbiu_code = `CBIU_ST_CODE;
      K_MEM_RD: cbiu_code = `CBIU_ST_MEM_RD;
      K_MEM_WR: cbiu_code = `CBIU_ST_MEM_WR;
      default: cbiu_code = `CBIU_ST_PASSIVE;
    endcase
  endfunction : cbiu_code

  // vector table pointer from a type byte
  function automatic logic [9:0] cbiu_vec(input cbiu_byte_t t);
    cbiu_vec = {2'h0, t} << `CBIU_VEC_SHIFT;
  endfunction : cbiu_vec

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  logic [1:0] rst_sync; // reset release chain
  logic rst_n; // released reset
  logic strap_meta, strap_sync; // mode strap sync
  logic ready_meta, ready_sync; // ready sync
  cbiu_byte_t din_meta, din_sync; // data lane sync

  // two flops release the reset
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // two flops on every pin input
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_meta <= 1'b1;
      strap_sync <= 1'b1;
      ready_meta <= 1'b0;
      ready_sync <= 1'b0;
      din_meta <= 8'h00;
      din_sync <= 8'h00;
    end
    else
    begin
      strap_meta <= mode_strap_i;
      strap_sync <= strap_meta;
      ready_meta <= ready_i;
      ready_sync <= ready_meta;
      din_meta <= muxed_addr_data_low_i;
      din_sync <= din_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and decode
  cbiu_state_e state, next_state; // bus sequencer
  cbiu_kind_e op_kind; // kind of running operation
  logic [15:0] op_addr; // first byte address
  logic [15:0] op_wdata; // write word
  logic op_word; // two byte cycles
  logic op_second; // second byte cycle running
  logic op_eu; // operation from execution side
  cbiu_byte_t lo_byte; // first byte read
  logic [15:0] fetch_ip; // next prefetch address
  logic [2:0] q_cnt; // bytes held in queue
  logic [1:0] wr_ptr, rd_ptr; // queue pointers
  logic fetch_dead; // running fetch was flushed
  logic q_stale; // read register not yet current
  logic halt_ale; // delayed latch strobe for halt
  cbiu_byte_t ad_out; // lane output register
  logic ad_oe; // lane drive enable register
  cbiu_byte_t upper; // upper address register

  wire min_mode = strap_sync;
  wire in_cycle = state inside {S_T1, S_T2, S_T3, S_TW, S_T4};
  wire data_phase = state inside {S_T2, S_T3, S_TW};
  wire halting = state inside {S_HLT_DLY, S_HALTED};
  wire is_wr = op_kind inside {K_MEM_WR, K_IO_WR};
  wire is_ack = op_kind == K_IRQ_ACK;
  wire is_io = op_kind inside {K_IO_RD, K_IO_WR};
  wire op_more = op_word && !op_second;
  wire last_t = state == S_T4;
  wire fetch_busy = in_cycle && op_kind == K_CODE;
  wire [3:0] q_used = {1'b0, q_cnt} + {3'h0, fetch_busy};
  wire q_room = q_used < `CBIU_Q_DEPTH;
  wire eu_take = req_valid_i && req_ready_o;
  wire fetch_take = req_ready_o && !req_valid_i && q_room && !fetch_load_i;
  wire eu_halt = eu_take && req_kind_i == K_HALT;
  wire q_wr = last_t && op_kind == K_CODE && !fetch_dead && !fetch_load_i;
  wire q_pop = q_pop_i && q_valid_o;
  wire [1:0] next_rd_ptr = fetch_load_i ? 2'h0 : rd_ptr + {1'b0, q_pop};
  wire [15:0] start_addr = eu_take ? req_addr_i : fetch_take ? fetch_ip : op_addr + 16'h0001;
  wire next_ack = eu_take ? req_kind_i == K_IRQ_ACK : is_ack;
  wire enter_t1 = next_state == S_T1;
  // one lane only: write byte picked from low or high half
  wire [7:0] wbyte = op_second ? op_wdata[15:8] : op_wdata[7:0];
  wire [2:0] st_code = cbiu_code(op_kind);

  assign req_ready_o = state == S_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    next_state = state;
    unique case (state)
      S_IDLE:
        if (eu_halt)
          next_state = min_mode ? S_HLT_DLY : S_HALTED;
        else if (eu_take || fetch_take)
          next_state = S_T1;
      S_T1: next_state = S_T2;
      S_T2: next_state = S_T3;
      // wait while ready is low
      S_T3, S_TW: next_state = ready_sync ? S_T4 : S_TW;
      // second byte follows back to back
      S_T4: next_state = op_more ? S_T1 : S_IDLE;
      S_HLT_DLY: next_state = S_HALTED;
      S_HALTED: next_state = wake_i ? S_IDLE : S_HALTED;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and operation registers
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= S_IDLE;
      op_kind <= K_MEM_RD;
      op_addr <= 16'h0000;
      op_wdata <= 16'h0000;
      op_word <= 1'b0;
      op_second <= 1'b0;
      op_eu <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (eu_take)
      begin
        op_kind <= req_kind_i;
        op_addr <= req_addr_i;
        op_wdata <= req_wdata_i;
        op_word <= req_word_i || req_kind_i == K_IRQ_ACK;
        op_second <= 1'b0;
        op_eu <= 1'b1;
      end
      else if (fetch_take)
      begin
        op_kind <= K_CODE;
        op_addr <= fetch_ip;
        op_word <= 1'b0;
        op_second <= 1'b0;
        op_eu <= 1'b0;
      end
      else if (last_t && op_more)
        op_second <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lane, upper address and halt strobe registers
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ad_out <= 8'h00;
      ad_oe <= 1'b0;
      upper <= 8'h00;
      halt_ale <= 1'b0;
    end
    else
    begin
      halt_ale <= state == S_HLT_DLY;
      // address out in T1, write data from T2, bus floats for reads
      if (enter_t1)
        ad_out <= start_addr[7:0];
      else if (state == S_T1)
        ad_out <= wbyte;
      if (enter_t1)
        ad_oe <= !next_ack;
      else
        ad_oe <= next_state inside {S_T2, S_T3, S_TW, S_T4} && is_wr;
      if (enter_t1 && !next_ack)
        upper <= start_addr[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read capture and answers
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lo_byte <= 8'h00;
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 16'h0000;
      vector_ptr_o <= 10'h000;
    end
    else
    begin
      rsp_valid_o <= last_t && !op_more && op_eu;
      if (last_t && op_more)
        lo_byte <= din_sync;
      if (last_t && !op_more && op_eu && !is_wr)
        rsp_data_o <= op_word ? {din_sync, lo_byte} : {8'h00, din_sync};
      if (last_t && is_ack && op_second)
        vector_ptr_o <= cbiu_vec(din_sync);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prefetch queue control
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fetch_ip <= `CBIU_FETCH_RST;
      q_cnt <= 3'h0;
      wr_ptr <= 2'h0;
      rd_ptr <= 2'h0;
      fetch_dead <= 1'b0;
      q_stale <= 1'b0;
    end
    else
    begin
      rd_ptr <= next_rd_ptr;
      q_stale <= q_wr && wr_ptr == next_rd_ptr;
      if (fetch_load_i)
      begin
        fetch_ip <= fetch_addr_i;
        q_cnt <= 3'h0;
        wr_ptr <= 2'h0;
        fetch_dead <= fetch_busy;
      end
      else
      begin
        if (fetch_take)
        begin
          fetch_ip <= fetch_ip + 16'h0001;
          fetch_dead <= 1'b0;
        end
        if (q_wr)
          wr_ptr <= wr_ptr + 2'h1;
        q_cnt <= q_cnt + {2'h0, q_wr} - {2'h0, q_pop};
      end
    end
  end

  assign q_valid_o = q_cnt != 3'h0 && !q_stale;

  // queue storage
  cbiu_queue_mem u_qmem (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .wr_en_i(q_wr),
    .wr_addr_i(wr_ptr),
    .wr_data_i(din_sync),
    .rd_addr_i(next_rd_ptr),
    .rd_data_o(q_data_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin decode
  assign muxed_addr_data_low_o = ad_out;
  assign muxed_addr_data_low_oe_o = ad_oe;
  assign upper_address_lines_o = upper;
  // direct strobes only in minimum mode
  assign addr_latch_strobe_o = min_mode && (state == S_T1 || halt_ale);
  assign read_strobe_n_o = !(min_mode && data_phase && !is_wr && !is_ack);
  assign write_strobe_n_o = !(min_mode && data_phase && is_wr);
  assign irq_ack_strobe_n_o = !(min_mode && data_phase && is_ack);
  assign io_not_mem_o = min_mode && (in_cycle || halting) && is_io;
  assign xcvr_direction_o = !(min_mode && in_cycle && !is_wr);
  assign xcvr_enable_n_o = !(min_mode && state inside {S_T2, S_T3, S_TW, S_T4});
  // coded status in maximum mode, passive otherwise
  wire st_show = !min_mode && (state inside {S_T1, S_T2} || halting);
  wire [2:0] st_pins = st_show ? st_code : `CBIU_ST_PASSIVE;
  assign cycle_status_2_o = st_pins[2];
  assign cycle_status_1_o = st_pins[1];
  assign cycle_status_0_o = st_pins[0];
  assign min_mode_status_bit_o = (min_mode && (in_cycle || halting)) ? st_code[0] : 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  cbiu_byte_t din_sync_q; // type byte one edge late, for the vector check
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n);

  sequence rd_start;
    state == S_T1 && min_mode && !is_wr && !is_ack;
  endsequence
  sequence rd_t2;
    state == S_T2 && !muxed_addr_data_low_oe_o && !read_strobe_n_o;
  endsequence
  sequence wr_t2;
    state == S_T2 && muxed_addr_data_low_oe_o && !write_strobe_n_o;
  endsequence

  latch_in_t1_a: assert property ((state == S_T1 && min_mode) |-> addr_latch_strobe_o ##1 !addr_latch_strobe_o)
    else $error("latch strobe not a T1 pulse");
  upper_held_a: assert property ((state inside {S_T2, S_T3, S_TW, S_T4}) |-> $stable(upper_address_lines_o))
    else $error("upper address moved in cycle");
  iom_stable_a: assert property ((state inside {S_T2, S_T3, S_TW, S_T4}) |-> $stable(io_not_mem_o))
    else $error("io_not_mem moved in cycle");
  read_float_a: assert property (rd_start |=> rd_t2)
    else $error("read did not float bus and strobe in T2");
  write_data_a: assert property ((state == S_T1 && min_mode && is_wr) |=> wr_t2 ##1 muxed_addr_data_low_oe_o)
    else $error("write data or strobe missing");
  ack_nodrive_a: assert property ((state == S_T1 && is_ack) |-> !muxed_addr_data_low_oe_o)
    else $error("address driven in acknowledge");
  vector_times_four_a: assert property ((last_t && is_ack && op_second) |=> vector_ptr_o == {din_sync_q, 2'h0})
    else $error("vector pointer not type times four");
  status_code_a: assert property ((state == S_T1 && !min_mode) |-> st_pins == cbiu_code(op_kind) && addr_latch_strobe_o == 1'b0)
    else $error("status code wrong in maximum mode");
  wait_ready_a: assert property ((state inside {S_T3, S_TW} && !ready_sync) |=> state == S_TW)
    else $error("no wait state while ready low");
  halt_delay_a: assert property ((state == S_HLT_DLY && min_mode) |-> !addr_latch_strobe_o ##1 addr_latch_strobe_o)
    else $error("halt latch strobe not delayed");
  queue_bound_a: assert property ({1'b0, q_cnt} <= `CBIU_Q_DEPTH)
    else $error("queue over four bytes");

  // type byte as seen at the capturing edge, for the vector check
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      din_sync_q <= 8'h00;
    else
      din_sync_q <= din_sync;
  end
endmodule : cbiu_bus_unit

//--- logic/cbiu_regs.svh
// constants of the byte bus interface unit
`ifndef CBIU_REGS_SVH
`define CBIU_REGS_SVH
// prefetch queue depth in bytes
`define CBIU_Q_DEPTH 4'h4
// shift that turns an interrupt type into a vector table pointer
`define CBIU_VEC_SHIFT 2
// coded cycle status values
`define CBIU_ST_IRQ_ACK 3'h0
`define CBIU_ST_IO_RD 3'h1
`define CBIU_ST_IO_WR 3'h2
`define CBIU_ST_HALT 3'h3
`define CBIU_ST_CODE 3'h4
`define CBIU_ST_MEM_RD 3'h5
`define CBIU_ST_MEM_WR 3'h6
`define CBIU_ST_PASSIVE 3'h7
// reset value of the prefetch address
`define CBIU_FETCH_RST 16'h0000
`endif

//--- logic/cbiu_pkg.sv
// types shared by the byte bus interface unit
package cbiu_pkg;
  // bus sequencer states
  typedef enum logic [2:0] {S_IDLE, S_T1, S_T2, S_T3, S_TW, S_T4, S_HLT_DLY, S_HALTED} cbiu_state_e;
  // kinds of request from the execution side
  typedef enum logic [2:0] {K_MEM_RD, K_IO_RD, K_MEM_WR, K_IO_WR, K_IRQ_ACK, K_HALT, K_CODE} cbiu_kind_e;
  // one byte of the data lane
  typedef logic [7:0] cbiu_byte_t;
endpackage : cbiu_pkg

//--- logic/cbiu_queue_mem.sv
// storage of the instruction prefetch queue, registered read
`timescale 1ns/1ns
module cbiu_queue_mem
  import cbiu_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [1:0] wr_addr_i,
  input wire cbiu_byte_t wr_data_i,
  input wire logic [1:0] rd_addr_i,
  output cbiu_byte_t rd_data_o
);
  // four byte slots
  cbiu_byte_t mem [0:3];

  ////////////////////////////////////////////////////////////////////////////
  // write port
  always_ff @(posedge sys_clk_i)
  begin
    if (wr_en_i)
      mem[wr_addr_i] <= wr_data_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read register, cleared at reset
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rd_data_o <= 8'h00;
    else
      rd_data_o <= mem[rd_addr_i];
  end
endmodule : cbiu_queue_mem

//--- sim/cbiu_target_model.sv
// far side of the byte bus: memory, i/o ports and interrupt type source
`timescale 1ns/1ns
`include "cbiu_regs.svh"
module cbiu_target_model (
  input wire logic sys_clk_i,
  input wire logic [7:0] lane_i,
  input wire logic dut_oe_i,
  input wire logic [7:0] upper_i,
  input wire logic io_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic ack_n_i,
  input wire logic ale_i,
  input wire logic dir_i,
  input wire logic den_n_i,
  input wire logic sso_i,
  input wire logic [2:0] st_i,
  input wire logic slow_i,
  input wire logic [2:0] lat_i,
  input wire logic [7:0] type_i,
  output logic drv_oe_o,
  output logic [7:0] drv_data_o,
  output logic ready_o
);
  logic [7:0] mem [logic [16:0]];
  logic [15:0] cur_addr = 16'h0000;
  logic cur_io = 1'b0;
  logic [7:0] rd_val = 8'h00;
  logic [7:0] wd = 8'h00;
  logic rd_q = 1'b1;
  logic wr_q = 1'b1;
  logic ack_q = 1'b1;
  logic ale_q = 1'b0;
  int cnt = 0, last_w = 0, n_ale = 0, n_rd = 0, n_wr = 0, n_ack = 0, viol = 0;
  // bus controller view of the coded status in maximum mode
  int n_cale = 0, n_xoff = 0;
  logic [2:0] st_q = `CBIU_ST_PASSIVE;
  wire strb = !rd_n_i || !ack_n_i || !wr_n_i;
  // unwritten places answer with a pattern of their address
  function automatic logic [7:0] peek(input logic io, input logic [15:0] a);
    if (mem.exists({io, a}))
      return mem[{io, a}];
    return a[7:0] ^ a[15:8] ^ (io ? 8'h3C : 8'hA5);
  endfunction : peek
  // drive only while selected; data is garbled until ready is raised
  assign drv_oe_o = !rd_n_i || !ack_n_i;
  assign drv_data_o = (!ack_n_i ? type_i : rd_val) ^ (ready_o ? 8'h00 : 8'hFF);
  initial ready_o = 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  // sample the bus each rising edge, count cycles and note protocol faults
  always @(posedge sys_clk_i)
  begin
    if (ale_i && !ale_q)
    begin
      n_ale++;
      cur_addr = {upper_i, lane_i};
      cur_io = io_i;
      rd_val = peek(io_i, {upper_i, lane_i});
    end
    if (strb && (upper_i !== cur_addr[15:8] || io_i !== cur_io))
      viol++;
    if ((!rd_n_i || !ack_n_i) && (dut_oe_i || dir_i || den_n_i || (!ack_n_i && sso_i)))
      viol++;
    if (!wr_n_i && (!dut_oe_i || !dir_i || den_n_i || sso_i || (!wr_q && lane_i !== wd)))
      viol++;
    if (!wr_n_i)
      wd = lane_i;
    // end of a write: data must still stand in T4
    if (wr_n_i && !wr_q)
    begin
      if (!dut_oe_i || lane_i !== wd)
        viol++;
      mem[{cur_io, cur_addr}] = wd;
      n_wr++;
    end
    if (rd_n_i && !rd_q)
      n_rd++;
    if (ack_n_i && !ack_q)
      n_ack++;
    cnt = strb ? cnt + 1 : 0;
    if (strb)
      last_w = cnt;
    // slow target holds ready low for lat cycles of strobe
    ready_o <= !slow_i || (strb && cnt >= lat_i);
    // controller latch strobe as the status leaves passive
    if (st_i != `CBIU_ST_PASSIVE && st_q == `CBIU_ST_PASSIVE)
      n_cale++;
    // advanced write opens now; the normal write one clock on needs data
    if (st_q inside {`CBIU_ST_MEM_WR, `CBIU_ST_IO_WR} && st_i == st_q && !dut_oe_i)
      viol++;
    // type read from the local interrupt controller: transceiver held off
    if (st_i == `CBIU_ST_IRQ_ACK && st_q != st_i)
      n_xoff++;
    st_q = st_i;
    rd_q = rd_n_i;
    wr_q = wr_n_i;
    ack_q = ack_n_i;
    ale_q = ale_i;
  end
endmodule : cbiu_target_model

//--- sim/tb_cbiu_bus_unit.sv
// self-checking bench of the byte bus interface unit
`timescale 1ns/1ns
`include "cbiu_regs.svh"
module tb_cbiu_bus_unit import cbiu_pkg::*;;
  logic clk = 1'b0, rst_b = 1'b0, strap = 1'b1, valid = 1'b0, word = 1'b0;
  logic fl = 1'b0, pop = 1'b0, wake = 1'b0, slow = 1'b0;
  logic [2:0] lat = 3'h1;
  logic [7:0] ityp = 8'h00, hold = 8'h00;
  logic [15:0] addr = 16'h0000, wdat = 16'h0000, faddr = 16'h0000;
  cbiu_kind_e kind = K_MEM_RD;
  logic [7:0] lo, up, m_data;
  cbiu_byte_t qd;
  logic oe, io, rd_n, wr_n, ack_n, ale, dir, den_n, s2, s1, s0, min_mode_status_bit, rdy, m_oe, m_rdy, rsp_v, qv;
  logic [15:0] rsp;
  logic [9:0] vp;
  logic [2:0] st;
  logic [31:0] r, lfsr = 32'h05F34765;
  logic [7:0] shadow [logic [16:0]];
  int cyc = 0, n_fail = 0, compares = 0, t0, ale_k, rlat, i, n, n0, n1;
  cbiu_kind_e ops [4] = '{K_MEM_RD, K_IO_RD, K_MEM_WR, K_IO_WR};
  cbiu_kind_e mk [6] = '{K_MEM_RD, K_IO_RD, K_MEM_WR, K_IO_WR, K_IRQ_ACK, K_HALT};
  logic [2:0] mc [6] = '{`CBIU_ST_MEM_RD, `CBIU_ST_IO_RD, `CBIU_ST_MEM_WR, `CBIU_ST_IO_WR,
                          `CBIU_ST_IRQ_ACK, `CBIU_ST_HALT};
  // released lane keeps its last level, as bus-hold does
  wire [7:0] lane = oe ? lo : (m_oe ? m_data : hold);
  always #20 clk = ~clk;
  always @(posedge clk) hold <= lane;
  // cycle count and hang limit
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      test_done();
    end
  end
  cbiu_bus_unit dut_u (.sys_clk_i(clk), .rst_b_i(rst_b), .mode_strap_i(strap), .ready_i(m_rdy),
    .muxed_addr_data_low_i(lane), .muxed_addr_data_low_o(lo), .muxed_addr_data_low_oe_o(oe),
    .upper_address_lines_o(up), .io_not_mem_o(io), .read_strobe_n_o(rd_n),
    .write_strobe_n_o(wr_n), .irq_ack_strobe_n_o(ack_n), .addr_latch_strobe_o(ale),
    .xcvr_direction_o(dir), .xcvr_enable_n_o(den_n), .cycle_status_2_o(s2),
    .cycle_status_1_o(s1), .cycle_status_0_o(s0), .min_mode_status_bit_o(min_mode_status_bit),
    .req_valid_i(valid), .req_ready_o(rdy), .req_kind_i(kind), .req_word_i(word),
    .req_addr_i(addr), .req_wdata_i(wdat), .rsp_valid_o(rsp_v), .rsp_data_o(rsp),
    .vector_ptr_o(vp), .wake_i(wake), .fetch_load_i(fl), .fetch_addr_i(faddr),
    .q_valid_o(qv), .q_data_o(qd), .q_pop_i(pop));
  cbiu_target_model mdl_u (.sys_clk_i(clk), .lane_i(lane), .dut_oe_i(oe), .upper_i(up),
    .io_i(io), .rd_n_i(rd_n), .wr_n_i(wr_n), .ack_n_i(ack_n), .ale_i(ale), .dir_i(dir),
    .den_n_i(den_n), .sso_i(min_mode_status_bit), .st_i({s2, s1, s0}), .slow_i(slow), .lat_i(lat), .type_i(ityp),
    .drv_oe_o(m_oe), .drv_data_o(m_data), .ready_o(m_rdy));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] exp_byte(input logic s, input logic [15:0] a);
    if (shadow.exists({s, a}))
      return shadow[{s, a}];
    return a[7:0] ^ a[15:8] ^ (s ? 8'h3C : 8'hA5);
  endfunction : exp_byte
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val
  task automatic chk_num(input string nm, input int e, input int g);
    compares++;
    if (g != e)
    begin
      n_fail++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_num
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // one request held until taken; notes latch delay, T1 status and latency
  task automatic do_op(input cbiu_kind_e k, input logic w, input logic [15:0] a,
                       input logic [15:0] d);
    int m;
    kind = k;
    word = w;
    addr = a;
    wdat = d;
    valid = 1'b1;
    m = 0;
    while (rdy !== 1'b1 && m < 300)
    begin
      @(negedge clk);
      m++;
    end
    @(negedge clk);
    valid = 1'b0;
    t0 = cyc;
    st = {s2, s1, s0};
    ale_k = 1;
    while (strap && ale !== 1'b1 && ale_k < 4)
    begin
      @(negedge clk);
      ale_k++;
    end
    while (k != K_HALT && rsp_v !== 1'b1 && cyc - t0 < 300)
      @(negedge clk);
    rlat = cyc - t0;
  endtask : do_op
  task automatic wake_up();
    wake = 1'b1;
    repeat (2) @(negedge clk);
    wake = 1'b0;
  endtask : wake_up
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    // let the prefetch queue fill so no fetch mixes into the counts
    repeat (40) @(negedge clk);
    // random traffic; first a word write and read across an upper byte carry
    for (i = 0; i < 24; i++)
    begin
      r = rnd();
      if (i < 2)
        r = {16'h00FF, 13'h0000, 1'b1, (i == 0) ? 2'h2 : 2'h0};
      slow = r[3];
      lat = {1'b0, r[5:4]} + 3'h1;
      n0 = mdl_u.n_ale;
      do_op(ops[r[1:0]], r[2], {1'b0, r[30:16]}, r[15:0] ^ r[31:16]);
      if (r[1])
      begin
        shadow[{r[0], addr}] = wdat[7:0];
        if (r[2])
          shadow[{r[0], addr + 16'h0001}] = wdat[15:8];
      end
      else
        chk_val("read data", r[2] ? {exp_byte(r[0], addr + 16'h0001), exp_byte(r[0], addr)}
          : {8'h00, exp_byte(r[0], addr)}, rsp);
      chk_num("latch pulses", r[2] ? 2 : 1, mdl_u.n_ale - n0);
      chk_num("latch delay", 1, ale_k);
      chk_val("io select", {15'h0000, r[0]}, {15'h0000, mdl_u.cur_io});
      chk_val("min status", 16'h0007, {13'h0000, st});
      if (slow)
        chk_num("waited", 1, int'(rlat > (r[2] ? 8 : 4)));
      else
      begin
        chk_num("cycle time", r[2] ? 8 : 4, rlat);
        chk_num("strobe width", 2, mdl_u.last_w);
      end
    end
    slow = 1'b0;
    $display("test traffic done");
    // acknowledge pairs: extreme type first, then random
    for (i = 0; i < 2; i++)
    begin
      r = rnd();
      ityp = (i == 0) ? 8'hFF : r[7:0];
      n0 = mdl_u.n_ack;
      do_op(K_IRQ_ACK, 1'b0, 16'h0000, 16'h0000);
      chk_val("vector pointer", {6'h00, ityp, 2'b00}, {6'h00, vp});
      chk_num("ack cycles", 2, mdl_u.n_ack - n0);
    end
    do_op(K_HALT, 1'b0, 16'h0000, 16'h0000);
    chk_num("halt latch delay", 2, ale_k);
    wake_up();
    $display("test ack and halt done");
    // coded status mode: every cycle type, no direct strobes
    strap = 1'b0;
    repeat (6) @(negedge clk);
    for (i = 0; i < 6; i++)
    begin
      n0 = mdl_u.n_ale + mdl_u.n_rd + mdl_u.n_wr + mdl_u.n_ack;
      n = mdl_u.n_cale;
      n1 = mdl_u.n_xoff;
      do_op(mk[i], 1'b0, 16'h0040, 16'h00C3);
      chk_val("cycle status", {13'h0000, mc[i]}, {13'h0000, st});
      if (mk[i] == K_HALT)
        wake_up();
      chk_num("strobe count", n0, mdl_u.n_ale + mdl_u.n_rd + mdl_u.n_wr + mdl_u.n_ack);
      chk_num("controller latches", (mk[i] == K_IRQ_ACK) ? 2 : 1, mdl_u.n_cale - n);
      chk_num("xcvr disables", (mk[i] == K_IRQ_ACK) ? 2 : 0, mdl_u.n_xoff - n1);
    end
    pop = 1'b1;
    @(negedge clk);
    pop = 1'b0;
    n = 0;
    while ({s2, s1, s0} !== `CBIU_ST_CODE && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    chk_num("code status", 1, int'(n < 20));
    // the strap only moves while the bus is idle
    repeat (8) @(negedge clk);
    strap = 1'b1;
    repeat (40) @(negedge clk);
    $display("test coded status done");
    // flush, refill exactly four bytes, then pop in order
    n0 = mdl_u.n_rd;
    faddr = 16'hF000;
    fl = 1'b1;
    @(negedge clk);
    fl = 1'b0;
    repeat (60) @(negedge clk);
    chk_num("fetch count", 4, mdl_u.n_rd - n0);
    for (i = 0; i < 6; i++)
    begin
      n = 0;
      while (qv !== 1'b1 && n < 100)
      begin
        @(negedge clk);
        n++;
      end
      chk_val("queue byte", {8'h00, exp_byte(1'b0, faddr + i[15:0])}, {8'h00, qd});
      pop = 1'b1;
      @(negedge clk);
      pop = 1'b0;
      @(negedge clk);
    end
    chk_num("bus faults", 0, mdl_u.viol);
    $display("test prefetch done");
    test_done();
  end
endmodule : tb_cbiu_bus_unit
